// file: hw/psk_demod_config_status.sv
// Configuration, status, output formatting and bus slave of the demodulator
// Notes on behaviour
// - Option bit 5 inverts Q, bit 6 differential
// - Differential symbol from phase change, quarter turns
// - Mode bits 1-0: parallel or serial, I first
// - Mode bit 2 enables the AFC
// - Mode bit 3 picks direct or shared bus
// - Mode bits 5-4 pick BPSK, QPSK, OQPSK
// - Writing one to bit 7 forces re-acquisition
// - Bus slave answers reads only on address match
// - Monitoring registers are read-only
// - Frequency offset 24-bit, three bytes, low first
// - Digital gain reported as 8-bit unsigned
// - Noise ratio reported as 8-bit unsigned
// - Lock status bit 0, one when locked
// - I and Q scatter samples, 8-bit signed
// - Transition flag: one transition per 1023 symbols
// - Defaults 0x40, 0x82, 0x00, others zero
// - Everything changes after the rising clock edge
// - Phase ambiguity left unresolved downstream
// - Symmetric 29-tap root-raised-cosine coefficients
// - Soft bits 4-bit unsigned, one-cycle strobe
// - Shared bus uses first connector only
`timescale 1ns/1ps
module psk_demod_config_status (
	input wire logic core_clk_in, // Reference clock
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic cfg_wr_en_in, // Register write strobe
	input wire logic [4:0] cfg_wr_addr_in, // Register write index
	input wire logic [7:0] cfg_wr_data_in, // Register write data
	input wire logic [4:0] cfg_rd_addr_in, // Register read index
	output logic [7:0] cfg_rd_data_out, // Read data, one cycle later
	input wire logic [23:0] freq_offset_in, // Core frequency offset
	input wire logic [7:0] digital_gain_in, // Core digital gain
	input wire logic [7:0] noise_ratio_in, // Core noise figure
	input wire logic carrier_lock_in, // Core carrier lock
	input wire logic freq_acquiring_in, // Core acquisition in progress
	input wire logic input_saturation_in, // Core saturation detector
	input wire logic [7:0] i_scatter_in, // I after digital gain
	input wire logic [7:0] q_scatter_in, // Q after digital gain
	input wire logic sym_stb_in, // Core symbol strobe
	input wire logic [3:0] soft_i_in, // Core soft I
	input wire logic [3:0] soft_q_in, // Core soft Q
	input wire logic [1:0] sym_phase_in, // Core symbol quadrant
	input wire logic sample_clk_pin_in, // External sample strobe pin
	input wire logic bus_clk_pin_in, // Shared bus clock pin
	input wire logic [3:0] bus_addr_pin_in, // Shared bus address pin
	input wire logic shared_bus_read_write_n_in, // Shared bus read/write-n
	input wire logic [4:0] coef_idx_in, // Filter tap index
	output logic signed [10:0] coef_out, // Filter tap value
	output logic ext_acq_en_out, // Extended acquisition enable
	output logic afc_en_out, // AFC enable
	output logic [1:0] mod_type_out, // Modulation select
	output logic reacq_out, // Re-acquisition pulse
	output logic sample_stb_out, // Input sample strobe
	output logic [3:0] data_i_out, // Soft I, direct connector
	output logic [3:0] data_q_out, // Soft Q, direct connector
	output logic bit_stb_out, // Soft output strobe
	output logic [7:0] bus_data_out, // Shared bus data
	output logic bus_data_oe_n_out, // Shared bus drive, low drives
	output logic carrier_lock_probe_out, // Carrier lock probe
	output logic bit_transition_probe_out, // Bit transition probe
	output logic freq_acquiring_probe_out, // Acquisition probe
	output logic input_saturation_probe_out // Saturation probe
);
	typedef struct packed {
		logic [psk_demod_pkg::CTRL_COUNT-1:0][7:0] ctrl;
		logic [7:0] rd_data;
		logic reacq;
		logic samp_stb;
		logic [3:0] soft_i;
		logic [3:0] soft_q;
		logic bit_stb;
		logic [3:0] held_i;
		logic [3:0] held_q;
		logic q_pending;
		logic [1:0] prev_phase;
		logic [psk_demod_pkg::TRANS_CNT_W-1:0] trans_cnt;
		logic trans_ind;
		logic bus_clk_prev;
		logic [7:0] bus_data;
		logic bus_oe_n;
		logic signed [10:0] coef;
		logic [3:0] probes;
	} core_state_type;

	core_state_type st_r;
	core_state_type st_nxt;
	logic samp_sync;
	logic bus_clk_sync;
	logic [3:0] bus_addr_sync;
	logic shared_bus_read_write_n_sync;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	sync_stage #(.WIDTH(1)) u_samp_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(sample_clk_pin_in),
		.sync_out(samp_sync)
	);

	sync_stage #(.WIDTH(6)) u_bus_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in({bus_clk_pin_in, shared_bus_read_write_n_in, bus_addr_pin_in}),
		.sync_out({bus_clk_sync, shared_bus_read_write_n_sync, bus_addr_sync})
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [7:0] opt;
		logic [7:0] mode;
		logic [1:0] dphase;
		logic [3:0] new_i;
		logic [3:0] new_q;
		logic shared;
		logic [4:0] tap;
		opt = st_r.ctrl[psk_demod_pkg::OPTION_OFS];
		mode = st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS];
		shared = mode[psk_demod_pkg::SHARED_BUS_BIT];
		dphase = 2'(sym_phase_in - st_r.prev_phase);
		new_i = soft_i_in;
		new_q = soft_q_in;
		tap = 5'h0;
		st_nxt = st_r;
		st_nxt.reacq = 1'b0;
		st_nxt.bit_stb = 1'b0;

		// Register writes; status indices fall outside the array
		if (cfg_wr_en_in && (cfg_wr_addr_in < 5'(psk_demod_pkg::CTRL_COUNT))) begin
			st_nxt.ctrl[cfg_wr_addr_in] = cfg_wr_data_in;
			if (cfg_wr_addr_in == psk_demod_pkg::OUT_MODE_OFS) begin
				st_nxt.reacq = cfg_wr_data_in[psk_demod_pkg::REACQ_BIT];
				// Self-clearing: no need for software to write it back
				st_nxt.ctrl[psk_demod_pkg::OUT_MODE_OFS][psk_demod_pkg::REACQ_BIT] = 1'b0;
			end
		end

		// Read mux; unmapped indices and the spare lock-status bits read zero
		case (cfg_rd_addr_in)
			psk_demod_pkg::FREQ_LOW_OFS: st_nxt.rd_data = freq_offset_in[7:0];
			psk_demod_pkg::FREQ_MID_OFS: st_nxt.rd_data = freq_offset_in[15:8];
			psk_demod_pkg::FREQ_HIGH_OFS: st_nxt.rd_data = freq_offset_in[23:16];
			psk_demod_pkg::GAIN_OFS: st_nxt.rd_data = digital_gain_in;
			psk_demod_pkg::NOISE_OFS: st_nxt.rd_data = noise_ratio_in;
			psk_demod_pkg::LOCK_OFS: st_nxt.rd_data = {7'h00, carrier_lock_in};
			psk_demod_pkg::I_SCATTER_OFS: st_nxt.rd_data = i_scatter_in;
			psk_demod_pkg::Q_SCATTER_OFS: st_nxt.rd_data = q_scatter_in;
			default: begin
				if (cfg_rd_addr_in < 5'(psk_demod_pkg::CTRL_COUNT)) begin
					st_nxt.rd_data = st_r.ctrl[cfg_rd_addr_in];
				end else begin
					st_nxt.rd_data = 8'h00;
				end
			end
		endcase

		// Sample strobe: every clock when forced, else the external pin
		st_nxt.samp_stb = mode[psk_demod_pkg::FORCE_FS_BIT] ? 1'b1 : samp_sync;

		// Symbol path; the core applies the OQPSK half-symbol lag before us
		if (sym_stb_in) begin
			if (opt[psk_demod_pkg::DIFF_DEC_BIT]) begin
				// Quarter turns 0..3 map straight onto 00,01,10,11
				new_i = dphase[1] ? psk_demod_pkg::SOFT_ONE : psk_demod_pkg::SOFT_ZERO;
				new_q = dphase[0] ? psk_demod_pkg::SOFT_ONE : psk_demod_pkg::SOFT_ZERO;
			end else if (opt[psk_demod_pkg::SPEC_INV_BIT]) begin
				new_q = ~soft_q_in;
			end
			// BPSK carries nothing on Q
			if (mode[5:4] == psk_demod_pkg::MOD_BPSK) begin
				new_q = psk_demod_pkg::SOFT_ZERO;
			end
			// No n*90 degree resolution here; left to the decoder
			st_nxt.prev_phase = sym_phase_in;
			st_nxt.held_i = new_i;
			st_nxt.held_q = new_q;
			// Transition watchdog counts symbols since last phase change
			if (sym_phase_in != st_r.prev_phase) begin
				st_nxt.trans_cnt = '0;
				st_nxt.trans_ind = 1'b1;
			end else if (st_r.trans_cnt >= 10'(psk_demod_pkg::TRANS_WINDOW - 1)) begin
				st_nxt.trans_ind = 1'b0;
			end else begin
				st_nxt.trans_cnt = 10'(st_r.trans_cnt + 10'h1);
			end
			if (!shared) begin
				st_nxt.bit_stb = 1'b1;
				st_nxt.soft_i = new_i;
				st_nxt.q_pending = (mode[1:0] == psk_demod_pkg::FMT_SERIAL);
				// Second connector unused in serial format
				st_nxt.soft_q = (mode[1:0] == psk_demod_pkg::FMT_SERIAL) ?
					psk_demod_pkg::SOFT_ZERO : new_q;
			end
		end else if (st_r.q_pending) begin
			// Q follows I one clock later; strobe spacing needs rate <= clk/2
			st_nxt.q_pending = 1'b0;
			st_nxt.bit_stb = 1'b1;
			st_nxt.soft_i = st_r.held_q;
		end

		// Shared bus: direct outputs idle, second connector off
		if (shared) begin
			st_nxt.soft_q = psk_demod_pkg::SOFT_ZERO;
			st_nxt.q_pending = 1'b0;
		end
		st_nxt.bus_clk_prev = bus_clk_sync;
		if (bus_clk_sync && !st_r.bus_clk_prev) begin
			if (shared && shared_bus_read_write_n_sync && (bus_addr_sync ==
				st_r.ctrl[psk_demod_pkg::BUS_ADDR_OFS][psk_demod_pkg::BUS_ADDR_W-1:0])) begin
				st_nxt.bus_data = {st_r.held_i, st_r.held_q};
				st_nxt.bus_oe_n = 1'b0;
			end else begin
				st_nxt.bus_oe_n = 1'b1;
			end
		end
		if (!shared) begin
			st_nxt.bus_oe_n = 1'b1;
		end

		// Coefficient lookup folds taps 15..28 onto 13..0
		if (coef_idx_in > 5'd14) begin
			tap = 5'(5'd28 - coef_idx_in);
		end else begin
			tap = coef_idx_in;
		end
		if (coef_idx_in < 5'(psk_demod_pkg::NUM_TAPS)) begin
			st_nxt.coef = psk_demod_pkg::RRC_HALF[tap[3:0]];
		end else begin
			st_nxt.coef = 11'sh000;
		end

		st_nxt.probes = {carrier_lock_in, freq_acquiring_in, input_saturation_in, 1'b0};
	end

	////////////////////////////////////////////////////////////////////////////
	// State register, rising edge only
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
			st_r.ctrl[psk_demod_pkg::CTRL_THIRD_OFS] <= psk_demod_pkg::CTRL_THIRD_RST;
			st_r.ctrl[psk_demod_pkg::OPTION_OFS] <= psk_demod_pkg::OPTION_RST;
			st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS] <= psk_demod_pkg::OUT_MODE_RST;
			st_r.bus_oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign cfg_rd_data_out = st_r.rd_data;
	assign ext_acq_en_out = st_r.ctrl[psk_demod_pkg::OPTION_OFS][psk_demod_pkg::EXT_ACQ_BIT];
	assign afc_en_out = st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS][psk_demod_pkg::AFC_BIT];
	assign mod_type_out = st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS][5:4];
	assign reacq_out = st_r.reacq;
	assign sample_stb_out = st_r.samp_stb;
	assign data_i_out = st_r.soft_i;
	assign data_q_out = st_r.soft_q;
	assign bit_stb_out = st_r.bit_stb;
	assign bus_data_out = st_r.bus_data;
	assign bus_data_oe_n_out = st_r.bus_oe_n;
	assign coef_out = st_r.coef;
	assign carrier_lock_probe_out = st_r.probes[3];
	assign freq_acquiring_probe_out = st_r.probes[2];
	assign input_saturation_probe_out = st_r.probes[1];
	assign bit_transition_probe_out = st_r.trans_ind;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_reacq_pulse;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(cfg_wr_en_in && cfg_wr_addr_in == psk_demod_pkg::OUT_MODE_OFS && cfg_wr_data_in[7])
		|=> reacq_out ##1 !reacq_out;
	endproperty
	a_reacq_pulse: assert property (p_reacq_pulse) else $error("reacq not one pulse");

	property p_reacq_reads_zero;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(cfg_rd_addr_in == psk_demod_pkg::OUT_MODE_OFS) |=> !cfg_rd_data_out[7];
	endproperty
	a_reacq_reads_zero: assert property (p_reacq_reads_zero) else $error("reacq bit read one");

	property p_status_ro;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(cfg_wr_en_in && cfg_wr_addr_in >= 5'(psk_demod_pkg::CTRL_COUNT)) |=> $stable(st_r.ctrl);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed config");

	property p_lock_read;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(cfg_rd_addr_in == psk_demod_pkg::LOCK_OFS)
		|=> cfg_rd_data_out == {7'h00, $past(carrier_lock_in)};
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock status mismatch");

	property p_force_fs;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS][6] |=> sample_stb_out;
	endproperty
	a_force_fs: assert property (p_force_fs) else $error("forced strobe missing");

	property p_serial_pair;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sym_stb_in && st_r.ctrl[psk_demod_pkg::OUT_MODE_OFS][3:0] == 4'h1)
		|=> bit_stb_out ##1 (bit_stb_out && data_i_out == $past(st_r.held_q));
	endproperty
	a_serial_pair: assert property (p_serial_pair) else $error("serial I then Q broken");

	property p_transition;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sym_stb_in && sym_phase_in != st_r.prev_phase) |=> bit_transition_probe_out;
	endproperty
	a_transition: assert property (p_transition) else $error("transition flag not set");

	property p_bus_answer;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(bus_clk_sync && !st_r.bus_clk_prev && st_r.ctrl[7][3] && shared_bus_read_write_n_sync &&
		bus_addr_sync == st_r.ctrl[8][3:0]) |=> !bus_data_oe_n_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus slave failed to answer");

	property p_bus_quiet;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(!bus_data_oe_n_out) |-> (bus_addr_sync == st_r.ctrl[8][3:0] || $past(bus_addr_sync) ==
		st_r.ctrl[8][3:0] || $past(bus_addr_sync, 2) == st_r.ctrl[8][3:0]) || !$stable(st_r.ctrl);
	endproperty
	a_bus_quiet: assert property (p_bus_quiet) else $error("bus driven for other address");

	property p_diff_decode;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(sym_stb_in && st_r.ctrl[6][6] && !st_r.ctrl[7][3])
		|=> data_i_out == ($past(2'(sym_phase_in - st_r.prev_phase)) >= 2'h2 ? 4'hf : 4'h0);
	endproperty
	a_diff_decode: assert property (p_diff_decode) else $error("differential decode wrong");

	property p_defaults;
		@(posedge core_clk_in)
		!rst_n_in |=> (st_r.ctrl[6] == 8'h82 && st_r.ctrl[2] == 8'h40 && st_r.ctrl[7] == 8'h00);
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset defaults wrong");
endmodule

// file: hw/psk_demod_pkg.sv
// Shared constants for the demodulator configuration and status block
package psk_demod_pkg;

	// Register index space: control registers at 0..8, status at 0x18..0x1f
	localparam logic [4:0] CTRL_THIRD_OFS = 5'h02;
	localparam logic [4:0] OPTION_OFS = 5'h06;
	localparam logic [4:0] OUT_MODE_OFS = 5'h07;
	localparam logic [4:0] BUS_ADDR_OFS = 5'h08;
	localparam logic [4:0] FREQ_LOW_OFS = 5'h18;
	localparam logic [4:0] FREQ_MID_OFS = 5'h19;
	localparam logic [4:0] FREQ_HIGH_OFS = 5'h1a;
	localparam logic [4:0] GAIN_OFS = 5'h1b;
	localparam logic [4:0] NOISE_OFS = 5'h1c;
	localparam logic [4:0] LOCK_OFS = 5'h1d;
	localparam logic [4:0] I_SCATTER_OFS = 5'h1e;
	localparam logic [4:0] Q_SCATTER_OFS = 5'h1f;
	localparam int CTRL_COUNT = 9;

	// Reset values of the control registers
	localparam logic [7:0] CTRL_THIRD_RST = 8'h40;
	localparam logic [7:0] OPTION_RST = 8'h82;
	localparam logic [7:0] OUT_MODE_RST = 8'h00;
	localparam logic [7:0] OTHER_RST = 8'h00;

	// Option register fields
	localparam int EXT_ACQ_BIT = 4;
	localparam int SPEC_INV_BIT = 5;
	localparam int DIFF_DEC_BIT = 6;

	// Output mode register fields
	localparam int FMT_LSB = 0;
	localparam int AFC_BIT = 2;
	localparam int SHARED_BUS_BIT = 3;
	localparam int MOD_LSB = 4;
	localparam int FORCE_FS_BIT = 6;
	localparam int REACQ_BIT = 7;
	localparam int BUS_ADDR_W = 4;

	// Encodings
	localparam logic [1:0] FMT_PARALLEL = 2'h0;
	localparam logic [1:0] FMT_SERIAL = 2'h1;
	localparam logic [1:0] MOD_BPSK = 2'h0;
	localparam logic [1:0] MOD_QPSK = 2'h1;
	localparam logic [1:0] MOD_OQPSK = 2'h2;
	localparam logic [3:0] SOFT_ZERO = 4'h0;
	localparam logic [3:0] SOFT_ONE = 4'hf;

	// Bit transition window, in symbols
	localparam int TRANS_WINDOW = 1023;
	localparam int TRANS_CNT_W = 10;

	// Root-raised-cosine taps 0..14 in 1/1024 units; taps 15..28 mirror them
	localparam int NUM_TAPS = 29;
	localparam int COEF_W = 11;
	localparam logic signed [14:0][COEF_W-1:0] RRC_HALF = {
		11'sd272, 11'sd240, 11'sd160, 11'sd64, -11'sd16, -11'sd52, -11'sd48,
		-11'sd16, 11'sd12, 11'sd24, 11'sd24, 11'sd8, -11'sd8, -11'sd16, -11'sd8};

endpackage

// file: hw/sync_stage.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_stage #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_in, // Reference clock
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic [WIDTH-1:0] async_in, // Level from a pin
	output logic [WIDTH-1:0] sync_out // Level safe to read
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type st_r;
	sync_state_type st_nxt;

	// First stage feeds only the second
	always_comb begin
		st_nxt.first = async_in;
		st_nxt.second = st_r.first;
	end

	// Both stages reset to zero
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.second;
endmodule

// file: sim/soft_bit_sink.sv
// Downstream soft-bit consumer model for the demodulator bench
`timescale 1ns/1ps
module soft_bit_sink (
	input wire logic core_clk_in, // Reference clock
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic bit_stb_in, // Soft output strobe
	input wire logic [3:0] data_i_in, // Soft I
	input wire logic [3:0] data_q_in, // Soft Q
	output logic got_out, // High one cycle after each capture
	output logic [7:0] got_data_out // Captured {I,Q}
);
	// Capture only on the rising edge with the strobe high; lines between strobes mean nothing
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			got_out <= 1'b0;
			got_data_out <= 8'h00;
		end else begin
			got_out <= bit_stb_in;
			if (bit_stb_in) begin
				got_data_out <= {data_i_in, data_q_in};
			end
		end
	end
endmodule

// file: sim/tb_psk_demod_config_status.sv
// Self-checking bench for the demodulator configuration and status block
`timescale 1ns/1ps
module tb_psk_demod_config_status;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cfg_wr_en_in = 1'b0;
	logic [4:0] cfg_wr_addr_in = 5'h00;
	logic [7:0] cfg_wr_data_in = 8'h00;
	logic [4:0] cfg_rd_addr_in = 5'h00;
	logic [23:0] freq_offset_in = 24'h000000;
	logic [7:0] digital_gain_in = 8'h00;
	logic [7:0] noise_ratio_in = 8'h00;
	logic [7:0] i_scatter_in = 8'h00;
	logic [7:0] q_scatter_in = 8'h00;
	logic carrier_lock_in = 1'b0;
	logic freq_acquiring_in = 1'b0;
	logic input_saturation_in = 1'b0;
	logic sym_stb_in = 1'b0;
	logic [3:0] soft_i_in = 4'h0;
	logic [3:0] soft_q_in = 4'h0;
	logic [1:0] sym_phase_in = 2'h0;
	logic sample_clk_pin_in = 1'b1;
	logic bus_clk_pin_in = 1'b0;
	logic [3:0] bus_addr_pin_in = 4'h0;
	logic shared_bus_read_write_n_in = 1'b1;
	logic [4:0] coef_idx_in = 5'h00;
	logic [7:0] cfg_rd_data_out, bus_data_out, got_data_out;
	logic signed [10:0] coef_out;
	logic [1:0] mod_type_out;
	logic [3:0] data_i_out, data_q_out;
	logic ext_acq_en_out, afc_en_out, reacq_out, sample_stb_out, bit_stb_out;
	logic bus_data_oe_n_out, got_out, carrier_lock_probe_out, bit_transition_probe_out;
	logic freq_acquiring_probe_out, input_saturation_probe_out;
	int err_count = 0;
	int comparisons = 0;
	int seed = 66;
	int reacq_seen = 0;
	int tab[15] = '{-8, -16, -8, 8, 24, 24, 12, -16, -48, -52, -16, 64, 160, 240, 272};
	logic [7:0] exp_q[$];
	logic [7:0] opt = 8'h82;
	logic [7:0] mode = 8'h00;
	logic [7:0] last_bus = 8'h00;
	logic [1:0] prev_ph = 2'h0;

	psk_demod_config_status psk_demod_config_status_inst (.core_clk_in, .rst_n_in,
		.cfg_wr_en_in, .cfg_wr_addr_in, .cfg_wr_data_in, .cfg_rd_addr_in, .cfg_rd_data_out,
		.freq_offset_in, .digital_gain_in, .noise_ratio_in, .carrier_lock_in,
		.freq_acquiring_in, .input_saturation_in, .i_scatter_in, .q_scatter_in, .sym_stb_in,
		.soft_i_in, .soft_q_in, .sym_phase_in, .sample_clk_pin_in, .bus_clk_pin_in,
		.bus_addr_pin_in, .shared_bus_read_write_n_in, .coef_idx_in, .coef_out,
		.ext_acq_en_out, .afc_en_out, .mod_type_out, .reacq_out, .sample_stb_out,
		.data_i_out, .data_q_out, .bit_stb_out, .bus_data_out, .bus_data_oe_n_out,
		.carrier_lock_probe_out, .bit_transition_probe_out, .freq_acquiring_probe_out,
		.input_saturation_probe_out);
	soft_bit_sink soft_bit_sink_inst (.core_clk_in, .rst_n_in, .bit_stb_in(bit_stb_out),
		.data_i_in(data_i_out), .data_q_in(data_q_out), .got_out, .got_data_out);

	// 20 MHz reference clock
	always #25 core_clk_in = ~core_clk_in;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Write with an idle cycle after, so the strobe never toggles twice in one step
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		cfg_wr_en_in = 1'b1;
		cfg_wr_addr_in = a;
		cfg_wr_data_in = d;
		@(negedge core_clk_in);
		cfg_wr_en_in = 1'b0;
		@(negedge core_clk_in);
		if (a == 5'h06) opt = d;
		if (a == 5'h07) mode = {1'b0, d[6:0]};
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		cfg_rd_addr_in = a;
		@(negedge core_clk_in);
		check("rd_data", cfg_rd_data_out, exp);
	endtask

	// One symbol; expectations noted before the strobe, spaced for serial format
	task automatic send(input logic [3:0] i, input logic [3:0] q, input logic [1:0] ph);
		logic [1:0] d;
		logic [3:0] ei, eq;
		d = ph - prev_ph;
		prev_ph = ph;
		ei = i;
		eq = q;
		if (opt[6]) begin
			ei = {4{d[1]}};
			eq = {4{d[0]}};
		end else if (opt[5]) eq = ~q;
		if (mode[5:4] == 2'h0) eq = 4'h0;
		last_bus = {ei, eq};
		if (!mode[3] && mode[1:0] == 2'h1) begin
			exp_q.push_back({ei, 4'h0});
			exp_q.push_back({eq, 4'h0});
		end else if (!mode[3]) exp_q.push_back({ei, eq});
		sym_stb_in = 1'b1;
		soft_i_in = i;
		soft_q_in = q;
		sym_phase_in = ph;
		@(negedge core_clk_in);
		sym_stb_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
	endtask

	task automatic rsend();
		send(4'($random(seed)), 4'($random(seed)), 2'($random(seed)));
	endtask

	// Bus master read or write attempt; the clock pin holds each level for many core cycles
	task automatic bus(input logic [3:0] a, input logic r, input logic hit);
		bus_addr_pin_in = a;
		shared_bus_read_write_n_in = r;
		bus_clk_pin_in = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check("bus_oe_n", bus_data_oe_n_out, !hit);
		if (hit) check("bus_data", bus_data_out, last_bus);
		bus_clk_pin_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Soft output monitor: each capture consumes the oldest note
	always @(negedge core_clk_in) begin
		if (reacq_out === 1'b1) reacq_seen++;
		if (got_out === 1'b1) begin
			if (exp_q.size() == 0) check("stray_strobe", 24'h1, 24'h0);
			else check("soft_out", {16'h0, got_data_out}, {16'h0, exp_q.pop_front()});
		end
	end

	// Hang guard, well above the expected run of about 3400 cycles
	initial begin
		repeat (20000) @(posedge core_clk_in);
		err_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic [10:0] e;
		repeat (16) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		for (int k = 0; k < 9; k++) rd(5'(k), k == 2 ? 8'h40 : k == 6 ? 8'h82 : 8'h00);
		check("ext_acq", ext_acq_en_out, 24'h0);
		check("bus_oe_n", bus_data_oe_n_out, 24'h1);
		// Transition flag: set on a change, cleared by 1023 unchanged symbols
		send(4'h0, 4'h0, 2'h0);
		send(4'h0, 4'h0, 2'h1);
		check("transition", bit_transition_probe_out, 24'h1);
		repeat (1022) send(4'h0, 4'h0, 2'h1);
		check("transition", bit_transition_probe_out, 24'h1);
		send(4'h0, 4'h0, 2'h1);
		check("transition", bit_transition_probe_out, 24'h0);
		for (int k = 0; k < 6; k++) begin
			v = 8'($random(seed));
			wr(5'(k), v);
			rd(5'(k), v);
		end
		// Acquisition aids switched on, then off again once tracking
		wr(5'h06, 8'h92);
		check("ext_acq", ext_acq_en_out, 24'h1);
		wr(5'h06, 8'h82);
		check("ext_acq", ext_acq_en_out, 24'h0);
		wr(5'h07, 8'h04);
		check("afc", afc_en_out, 24'h1);
		wr(5'h07, 8'h00);
		check("afc", afc_en_out, 24'h0);
		for (int m = 0; m < 3; m++) begin
			wr(5'h07, 8'(m << 4));
			check("mod", mod_type_out, 24'(m));
			repeat (3) rsend();
		end
		wr(5'h06, 8'ha2);
		repeat (3) rsend();
		wr(5'h06, 8'hc2);
		for (int k = 0; k < 4; k++) send(4'($random(seed)), 4'h5, prev_ph + 2'(k));
		wr(5'h06, 8'h82);
		// Serial format only with QPSK, never BPSK
		wr(5'h07, 8'h11);
		repeat (3) rsend();
		wr(5'h07, 8'h90);
		repeat (3) @(negedge core_clk_in);
		check("reacq_pulses", 24'(reacq_seen), 24'h1);
		rd(5'h07, 8'h10);
		// Sample strobe follows the pin unless forced
		sample_clk_pin_in = 1'b0;
		repeat (5) @(negedge core_clk_in);
		check("sample_stb", sample_stb_out, 24'h0);
		sample_clk_pin_in = 1'b1;
		repeat (5) @(negedge core_clk_in);
		check("sample_stb", sample_stb_out, 24'h1);
		sample_clk_pin_in = 1'b0;
		wr(5'h07, 8'h50);
		repeat (4) @(negedge core_clk_in);
		check("sample_stb", sample_stb_out, 24'h1);
		wr(5'h07, 8'h10);
		repeat (4) begin
			freq_offset_in = 24'($random(seed));
			digital_gain_in = 8'($random(seed));
			noise_ratio_in = 8'($random(seed));
			i_scatter_in = 8'($random(seed));
			q_scatter_in = 8'($random(seed));
			{carrier_lock_in, freq_acquiring_in, input_saturation_in} = 3'($random(seed));
			@(negedge core_clk_in);
			check("lock_probe", carrier_lock_probe_out, 24'(carrier_lock_in));
			check("acq_probe", freq_acquiring_probe_out, 24'(freq_acquiring_in));
			check("sat_probe", input_saturation_probe_out, 24'(input_saturation_in));
			rd(5'h18, freq_offset_in[7:0]);
			rd(5'h19, freq_offset_in[15:8]);
			rd(5'h1a, freq_offset_in[23:16]);
			rd(5'h1b, digital_gain_in);
			rd(5'h1c, noise_ratio_in);
			rd(5'h1d, {7'h00, carrier_lock_in});
			rd(5'h1e, i_scatter_in);
			rd(5'h1f, q_scatter_in);
		end
		wr(5'h1b, ~digital_gain_in);
		rd(5'h1b, digital_gain_in);
		wr(5'h09, 8'hff);
		rd(5'h09, 8'h00);
		rd(5'h14, 8'h00);
		for (int k = 0; k < 32; k++) begin
			e = k < 15 ? 11'(tab[k]) : k < 29 ? 11'(tab[28 - k]) : 11'h000;
			coef_idx_in = 5'(k);
			@(negedge core_clk_in);
			check("coef", {13'h0000, coef_out}, {13'h0000, e});
		end
		// Shared bus: unique slave address, no strobes on the direct connector
		wr(5'h08, 8'h05);
		wr(5'h07, 8'h18);
		rsend();
		bus(4'h5, 1'b1, 1'b1);
		bus(4'h6, 1'b1, 1'b0);
		bus(4'h5, 1'b0, 1'b0);
		bus(4'h5, 1'b1, 1'b1);
		wr(5'h07, 8'h10);
		check("bus_oe_n", bus_data_oe_n_out, 24'h1);
		repeat (4) @(negedge core_clk_in);
		check("pending", 24'(exp_q.size()), 24'h0);
		conclude();
	end
endmodule
